/* File: verilog/rscc_pkg.sv */
/*
 Package for the reset, strap and clock configuration block: register map,
 field positions, strap encodings, state type and timing constants.
 Assumes a 50 MHz system clock and a 32-bit APB register bus.
*/
package rscc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] CTRL_OFS = 8'h04;
	localparam logic [1:0] WORD_ALIGN = 2'h0;

	// Status fields
	localparam int ST_WIDTH_LSB = 0;
	localparam int ST_POL_BIT = 2;
	localparam int ST_CLKSEL_BIT = 3;
	localparam int ST_ACTIVE_BIT = 4;
	localparam int ST_WDT_BIT = 5;

	// Control fields: bus clock code 0..4 = 125/100/75/50/25 MHz
	localparam int CLK_CODE_W = 3;
	localparam logic [2:0] CLK_CODE_RST = 3'h0;
	localparam logic [2:0] CLK_CODE_MAX = 3'h4;

	// ------------------------------------------------------------
	// Strap encodings
	// ------------------------------------------------------------
	localparam logic [1:0] WIDTH_RSVD = 2'h0;
	localparam logic [1:0] WIDTH_8 = 2'h1;
	localparam logic [1:0] WIDTH_16 = 2'h2;
	localparam logic [1:0] WIDTH_32 = 2'h3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 50;
	localparam int RST_HOLD_MS = 200;
	localparam int RST_HOLD_CYC = RST_HOLD_MS * 1000 * SYS_CLK_MHZ;
	localparam int HOLD_CNT_W = 24;

	typedef enum logic [1:0] {
		ST_CAPTURE,
		ST_HOLD,
		ST_RUN
	} rscc_state_type;

	// Bus width in bits for a bank-zero width strap; zero when reserved
	function automatic logic [5:0] rscc_width_bits(input logic [1:0] code);
		case (code)
			WIDTH_8: rscc_width_bits = 6'h08;
			WIDTH_16: rscc_width_bits = 6'h10;
			WIDTH_32: rscc_width_bits = 6'h20;
			default: rscc_width_bits = 6'h00;
		endcase
	endfunction

endpackage

/* File: verilog/rscc_top.sv */
/*
 Reset, strap capture and system clock configuration block.
 Assumes straps are held by the board across reset release, a one-cycle
 watchdog expiry pulse from the timer, and an APB master on the bus side.
*/
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
module rscc_top #(
	parameter int HOLD_CYCLES = rscc_pkg::RST_HOLD_CYC
) (
	// Clock and chip reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Strap pins and watchdog
	input wire logic [1:0] boot_bank_width_strap_i,
	input wire logic reset_out_polarity_strap_i,
	input wire logic cpu_clock_source_strap_i,
	input wire logic wdt_expire_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [rscc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Reset and configuration outputs
	output logic system_reset_out_o,
	output logic system_reset_out_oe_o,
	output logic core_reset_o,
	output logic cpu_clk_bypass_o,
	output logic [rscc_pkg::CLK_CODE_W-1:0] system_bus_clock_code_o,
	output logic [5:0] bank0_width_bits_o,
	output logic bank0_width_reserved_o
);
	import rscc_pkg::*;

	localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = HOLD_CNT_W'(HOLD_CYCLES - 1);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	rscc_state_type st_ff, nxt_st;
	logic [HOLD_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [1:0] width_ff, nxt_width;
	logic pol_ff, nxt_pol;
	logic clksel_ff, nxt_clksel;
	logic wdt_seen_ff, nxt_wdt_seen;
	logic [CLK_CODE_W-1:0] clk_code_ff, nxt_clk_code;
	logic rst_out_ff, nxt_rst_out;
	logic oe_ff, nxt_oe;
	logic core_rst_ff, nxt_core_rst;
	logic [5:0] wbits_ff, nxt_wbits;
	logic wrsvd_ff, nxt_wrsvd;
	logic bypass_ff, nxt_bypass;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [31:0] prdata_ff, nxt_prdata;
	logic setup, access, mapped, wdt_hit;

	// ------------------------------------------------------------
	// Sequencer and register file
	// ------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_width = width_ff;
		nxt_pol = pol_ff;
		nxt_clksel = clksel_ff;
		nxt_wdt_seen = wdt_seen_ff;
		nxt_clk_code = clk_code_ff;
		nxt_oe = oe_ff;
		wdt_hit = 1'b0;
		setup = psel_i & ~penable_i;
		access = psel_i & penable_i & pready_ff;
		mapped = (paddr_i == STATUS_OFS) || (paddr_i == CTRL_OFS);
		// Software writes act first so a hardware set in the same cycle wins
		if (access && pwrite_i && paddr_i == CTRL_OFS && pwdata_i[CLK_CODE_W-1:0] <= CLK_CODE_MAX) begin
			nxt_clk_code = pwdata_i[CLK_CODE_W-1:0];
		end
		if (access && pwrite_i && paddr_i == STATUS_OFS && pwdata_i[ST_WDT_BIT]) begin
			nxt_wdt_seen = 1'b0;
		end
		case (st_ff)
			ST_CAPTURE: begin
				// First edge after release: pins still carry the strap levels
				nxt_width = boot_bank_width_strap_i;
				nxt_pol = reset_out_polarity_strap_i;
				nxt_clksel = cpu_clock_source_strap_i;
				nxt_oe = 1'b1;
				nxt_cnt = '0;
				nxt_st = ST_HOLD;
			end
			ST_HOLD: begin
				if (wdt_expire_i) begin
					wdt_hit = 1'b1;
					nxt_cnt = '0;
				end else if (cnt_ff == HOLD_LAST) begin
					nxt_st = ST_RUN;
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			ST_RUN: begin
				if (wdt_expire_i) begin
					wdt_hit = 1'b1;
					nxt_cnt = '0;
					nxt_st = ST_HOLD;
				end
			end
			default: begin
				nxt_st = ST_CAPTURE;
			end
		endcase
		if (wdt_hit) begin
			// Internal reset returns the clock setting to its default
			nxt_wdt_seen = 1'b1;
			nxt_clk_code = CLK_CODE_RST;
		end
		nxt_rst_out = (nxt_st == ST_HOLD) ^ nxt_pol;
		nxt_core_rst = (nxt_st != ST_RUN);
		nxt_wbits = rscc_width_bits(nxt_width);
		nxt_wrsvd = (nxt_width == WIDTH_RSVD);
		nxt_bypass = nxt_clksel;
		// APB: one wait-free access phase, read data taken at setup
		nxt_pready = setup;
		nxt_pslverr = setup & ~(mapped && paddr_i[1:0] == WORD_ALIGN);
		nxt_prdata = prdata_ff;
		if (setup) begin
			nxt_prdata = '0;
			if (paddr_i == STATUS_OFS) begin
				nxt_prdata[ST_WIDTH_LSB +: 2] = width_ff;
				nxt_prdata[ST_POL_BIT] = pol_ff;
				nxt_prdata[ST_CLKSEL_BIT] = clksel_ff;
				nxt_prdata[ST_ACTIVE_BIT] = (st_ff == ST_HOLD);
				nxt_prdata[ST_WDT_BIT] = wdt_seen_ff;
			end else if (paddr_i == CTRL_OFS) begin
				nxt_prdata[CLK_CODE_W-1:0] = clk_code_ff;
			end
		end
	end

	// Output enable stays low through reset so the system reset output pin floats
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_ff <= ST_CAPTURE;
			cnt_ff <= '0;
			width_ff <= WIDTH_RSVD;
			pol_ff <= 1'b0;
			clksel_ff <= 1'b0;
			wdt_seen_ff <= 1'b0;
			clk_code_ff <= CLK_CODE_RST;
			rst_out_ff <= 1'b0;
			oe_ff <= 1'b0;
			core_rst_ff <= 1'b1;
			wbits_ff <= 6'h00;
			wrsvd_ff <= 1'b1;
			bypass_ff <= 1'b0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			width_ff <= nxt_width;
			pol_ff <= nxt_pol;
			clksel_ff <= nxt_clksel;
			wdt_seen_ff <= nxt_wdt_seen;
			clk_code_ff <= nxt_clk_code;
			rst_out_ff <= nxt_rst_out;
			oe_ff <= nxt_oe;
			core_rst_ff <= nxt_core_rst;
			wbits_ff <= nxt_wbits;
			wrsvd_ff <= nxt_wrsvd;
			bypass_ff <= nxt_bypass;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff <= nxt_prdata;
		end
	end

	assign system_reset_out_o = rst_out_ff;
	assign system_reset_out_oe_o = oe_ff;
	assign core_reset_o = core_rst_ff;
	assign cpu_clk_bypass_o = bypass_ff;
	assign system_bus_clock_code_o = clk_code_ff;
	assign bank0_width_bits_o = wbits_ff;
	assign bank0_width_reserved_o = wrsvd_ff;
	assign prdata_o = prdata_ff;
	assign pready_o = pready_ff;
	assign pslverr_o = pslverr_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	// Sampled reset in the antecedent: release lands on a clock edge, which is not yet the capture edge
	a_strap_capture: assert property (rst_b_i && st_ff == ST_CAPTURE |=> width_ff == $past(boot_bank_width_strap_i)
		&& pol_ff == $past(reset_out_polarity_strap_i)) else $error("strap not captured");
	a_width_decode: assert property (st_ff == ST_RUN |-> bank0_width_bits_o == rscc_width_bits(width_ff)
		&& bank0_width_reserved_o == (width_ff == WIDTH_RSVD)) else $error("width decode wrong");
	a_reset_polarity: assert property (st_ff != ST_CAPTURE |-> system_reset_out_o == ((st_ff == ST_HOLD) ^ pol_ff))
		else $error("reset out level wrong");
	a_cpu_bypass: assert property (st_ff != ST_CAPTURE |-> cpu_clk_bypass_o == clksel_ff)
		else $error("cpu clock source wrong");
	a_wdt_reset: assert property (st_ff == ST_RUN && wdt_expire_i |=> core_reset_o && st_ff == ST_HOLD
		&& wdt_seen_ff && system_bus_clock_code_o == CLK_CODE_RST) else $error("watchdog reset missing");
	a_clk_write: assert property (access && pwrite_i && paddr_i == CTRL_OFS && pwdata_i[2:0] <= CLK_CODE_MAX
		&& !wdt_expire_i |=> system_bus_clock_code_o == $past(pwdata_i[2:0])) else $error("clock code not written");
	a_hold_length: assert property ($fell(st_ff == ST_HOLD) |-> $past(cnt_ff) == HOLD_LAST)
		else $error("reset out released early");
	a_float_reset: assert property (rst_b_i && st_ff == ST_CAPTURE |-> !system_reset_out_oe_o ##1 system_reset_out_oe_o)
		else $error("pin driven during reset");
	a_strap_hold: assert property (st_ff != ST_CAPTURE |=> $stable(width_ff) && $stable(pol_ff) && $stable(clksel_ff))
		else $error("strap changed after capture");

	c_wdt_event: cover property (st_ff == ST_RUN ##1 wdt_expire_i ##1 core_reset_o);
	c_clk_write: cover property (access && pwrite_i && paddr_i == CTRL_OFS);
	c_hold_done: cover property ($fell(st_ff == ST_HOLD));
	c_bad_addr: cover property (pslverr_o && pready_o);

endmodule // rscc_top

/* File: dv/rscc_board.sv */
/*
 Board model: chip reset circuit and strap resistors.
 Assumes the bench calls board_reset on the shared clock.
*/
`timescale 1ns/1ns
module rscc_board #(
	parameter int STRAP_HOLD = 2
) (
	// Clock
	input wire logic sys_clk_i,
	// Reset and strap pins
	output logic rst_b_o,
	output logic [1:0] width_strap_o,
	output logic pol_strap_o,
	output logic clk_strap_o
);
	initial begin
		rst_b_o = 1'b0;
		width_strap_o = 2'h0;
		pol_strap_o = 1'b0;
		clk_strap_o = 1'b0;
	end
	// Straps stay a little past release, then the shared pins carry other traffic
	task automatic board_reset(input int cyc, input logic [1:0] w, input logic p, input logic c);
		@(posedge sys_clk_i);
		rst_b_o <= 1'b0;
		width_strap_o <= w;
		pol_strap_o <= p;
		clk_strap_o <= c;
		repeat (cyc) @(posedge sys_clk_i);
		rst_b_o <= 1'b1;
		repeat (STRAP_HOLD) @(posedge sys_clk_i);
		width_strap_o <= ~w;
		pol_strap_o <= ~p;
		clk_strap_o <= ~c;
	endtask
endmodule // rscc_board

/* File: dv/tb_top.sv */
/*
 Testbench for the reset, strap and clock block.
 Assumes the board model rscc_board and a 50 MHz clock.
*/
`timescale 1ns/1ns
module tb_top;
	import rscc_pkg::*;
	localparam int HOLD = 20;
	logic clk = 1'b0;
	logic rst_b, pol_s, clk_s, wdt = 1'b0;
	logic [1:0] w_s;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0, rd;
	logic rdy, err, r_out, r_oe, core, byp, rsvd;
	logic [2:0] code;
	logic [5:0] wbits;
	int n_errors = 0, n_compared = 0;
	always #10 clk = ~clk;
	rscc_board board_u (.sys_clk_i(clk), .rst_b_o(rst_b), .width_strap_o(w_s), .pol_strap_o(pol_s),
		.clk_strap_o(clk_s));
	rscc_top #(.HOLD_CYCLES(HOLD)) dut_u (.sys_clk_i(clk), .rst_b_i(rst_b), .boot_bank_width_strap_i(w_s),
		.reset_out_polarity_strap_i(pol_s), .cpu_clock_source_strap_i(clk_s), .wdt_expire_i(wdt),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wd), .prdata_o(rd),
		.pready_o(rdy), .pslverr_o(err), .system_reset_out_o(r_out), .system_reset_out_oe_o(r_oe),
		.core_reset_o(core), .cpu_clk_bypass_o(byp), .system_bus_clock_code_o(code),
		.bank0_width_bits_o(wbits), .bank0_width_reserved_o(rsvd));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Only the bench watchdog ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (rdy !== 1'b1);
		q = rd;
		e = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Counts negedges with the core still in reset
	task automatic hold_len(output int n);
		n = 0;
		while (core === 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic reset_case(input int cyc, input logic [1:0] w, input logic p, input logic c);
		int n;
		fork
			board_u.board_reset(cyc, w, p, c);
			begin
				repeat (3) @(negedge clk);
				chk("oe in reset", 1'b0, r_oe);
			end
		join
		@(negedge clk);
		chk("out asserted", !p, r_out);
		chk("oe driven", 1'b1, r_oe);
		hold_len(n);
		// Counting starts one edge later into the hold than after a watchdog hit
		chk("hold cycles", HOLD - 1, n);
		chk("out released", p, r_out);
		chk("width bits", (w == WIDTH_RSVD) ? 6'h00 : (6'h04 << w), wbits);
		chk("reserved", w == WIDTH_RSVD, rsvd);
		chk("bypass", c, byp);
		$display("reset case width %0d done", w);
	endtask
	task automatic apb_case();
		logic [31:0] q;
		logic e;
		apb(1'b0, CTRL_OFS, 32'h0, q, e);
		chk("ctrl reset", 32'h0, q);
		apb(1'b1, CTRL_OFS, 32'h4, q, e);
		chk("ctrl write ok", 1'b0, e);
		apb(1'b1, CTRL_OFS, 32'h5, q, e);
		apb(1'b0, CTRL_OFS, 32'h0, q, e);
		chk("ctrl value", 32'h4, q);
		chk("clock code", 3'h4, code);
		apb(1'b0, 8'h40, 32'h0, q, e);
		chk("unmapped error", 1'b1, e);
		$display("register case done");
	endtask
	task automatic wdt_case();
		logic [31:0] q;
		logic e;
		int n;
		@(posedge clk);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		@(negedge clk);
		chk("wdt core reset", 1'b1, core);
		// Last strap case set the output active low
		chk("wdt reset out", 1'b0, r_out);
		hold_len(n);
		chk("wdt hold", HOLD, n);
		apb(1'b0, STATUS_OFS, 32'h0, q, e);
		chk("wdt status", 1'b1, q[ST_WDT_BIT]);
		// Last strap case: 32-bit bank, active low output, PLL bypassed
		chk("status straps", {1'b1, 1'b1, WIDTH_32}, q[ST_CLKSEL_BIT:ST_WIDTH_LSB]);
		apb(1'b1, STATUS_OFS, 32'h1 << ST_WDT_BIT, q, e);
		apb(1'b0, STATUS_OFS, 32'h0, q, e);
		chk("wdt status clear", 1'b0, q[ST_WDT_BIT]);
		apb(1'b0, CTRL_OFS, 32'h0, q, e);
		chk("ctrl after wdt", 32'h0, q);
		$display("watchdog case done");
	endtask
	initial begin
		for (int i = 0; i < 4; i++) begin
			reset_case((i == 0) ? 12 : 256, i[1:0], i[0], i[1]);
		end
		apb_case();
		wdt_case();
		give_verdict();
	end
	// About 900 cycles are expected; ten thousand is ample
	initial begin
		#200000;
		n_errors++;
		give_verdict();
	end
endmodule // tb_top
